//--- logic/trc_pkg.sv
// Shared constants and types of the tiny RISC core sequencer
package trc_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int TRC_PC_W = 9;
  localparam int TRC_IW = 16;
  localparam int TRC_DW = 8;
  localparam int TRC_NREG = 32;
  localparam int TRC_IO_AW = 6;
  localparam int TRC_STK_DEPTH = 3;
  localparam int TRC_NIRQ = 3;
  // ----------------------------------------------------------------
  // Reset values, vectors, special registers
  // ----------------------------------------------------------------
  localparam logic [8:0] TRC_PC_RST = 9'h000;
  localparam logic [8:0] TRC_VEC_BASE = 9'h001;
  localparam logic [8:0] TRC_PC_INC = 9'h001;
  localparam logic [4:0] TRC_PTR_REG = 5'h1e;
  localparam logic [5:0] TRC_IO_STATUS = 6'h3f;
  localparam int TRC_SR_I = 7;
  localparam int TRC_SR_Z = 1;
  localparam int TRC_SR_C = 0;
  // ----------------------------------------------------------------
  // Opcode field [15:12]
  // ----------------------------------------------------------------
  localparam logic [3:0] TRC_MISC_OP = 4'h0;
  localparam logic [3:0] TRC_REG2_OP = 4'h1;
  localparam logic [3:0] TRC_SUB_IMM_WITH_CARRY_OP = 4'h2;
  localparam logic [3:0] TRC_SUB_IMM_OP = 4'h3;
  localparam logic [3:0] TRC_COMPARE_IMM_OP = 4'h4;
  localparam logic [3:0] TRC_AND_IMM_OP = 4'h5;
  localparam logic [3:0] TRC_OR_IMM_OP = 4'h6;
  localparam logic [3:0] TRC_LOAD_CONSTANT_OP = 4'h7;
  localparam logic [3:0] TRC_IO_OP = 4'h8;
  localparam logic [3:0] TRC_RELATIVE_JUMP_OP = 4'hc;
  localparam logic [3:0] TRC_RELATIVE_CALL_OP = 4'hd;
  // Misc sub-op field [11:8]
  localparam logic [3:0] TRC_NOP_SUB = 4'h0;
  localparam logic [3:0] TRC_SUBROUTINE_RETURN_SUB = 4'h1;
  localparam logic [3:0] TRC_INTERRUPT_RETURN_SUB = 4'h2;
  localparam logic [3:0] TRC_INC_SUB = 4'h3;
  localparam logic [3:0] TRC_LD_IND_SUB = 4'h4;
  localparam logic [3:0] TRC_ST_IND_SUB = 4'h5;
  // Two-register sub-op field [11:10]
  localparam logic [1:0] TRC_ADD_SUB = 2'h0;
  localparam logic [1:0] TRC_SUBTRACT_SUB = 2'h1;
  localparam logic [1:0] TRC_AND_SUB = 2'h2;
  localparam logic [1:0] TRC_MOV_SUB = 2'h3;
  // ----------------------------------------------------------------
  // Execute state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRC_ST_RUN = 2'b01,
    TRC_ST_IN = 2'b10
  } trc_state_e;
endpackage

//--- logic/trc_stack_if.sv
// Return-address stack connection between core and stack
`timescale 1ns/100ps
interface trc_stack_if;
  logic push;
  logic pop;
  logic [8:0] push_addr;
  logic [8:0] top;
  modport core (output push, output pop, output push_addr, input top);
  modport stack (input push, input pop, input push_addr, output top);
endinterface

//--- logic/trc_ret_stack.sv
// Three-level hardware return-address stack
`timescale 1ns/100ps
module trc_ret_stack (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Core side
  trc_stack_if.stack stk
);
  logic [8:0] lvl_q [trc_pkg::TRC_STK_DEPTH];
  logic [8:0] lvl_d [trc_pkg::TRC_STK_DEPTH];

  // ----------------------------------------------------------------
  // Level shifting
  // ----------------------------------------------------------------
  for (genvar i = 0; i < trc_pkg::TRC_STK_DEPTH; i++)
  begin : g_lvl
    // Push shifts deeper, dropping the oldest entry silently
    always_comb
    begin
      lvl_d[i] = lvl_q[i];
      if (stk.push)
      begin
        if (i == 0)
          lvl_d[i] = stk.push_addr;
        else
          lvl_d[i] = lvl_q[(i == 0) ? 0 : i - 1];
      end
      else if (stk.pop && (i < trc_pkg::TRC_STK_DEPTH - 1))
      begin
        lvl_d[i] = lvl_q[(i < trc_pkg::TRC_STK_DEPTH - 1) ? i + 1 : i];
      end
    end
    // Software may not rely on the contents after reset; clearing them keeps
    // the shift checks from comparing unknown levels on the first pushes
    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
        lvl_q[i] <= trc_pkg::TRC_PC_RST;
      else
        lvl_q[i] <= lvl_d[i];
    end
  end

  assign stk.top = lvl_q[0];

  chk_push_shift_down: assert property (@(posedge mclk) disable iff (!rstn)
    stk.push |=> (lvl_q[0] == $past(stk.push_addr)) && (lvl_q[1] == $past(lvl_q[0]))
      && (lvl_q[2] == $past(lvl_q[1])))
    else $error("push did not shift the stack down");
  chk_pop_shift_up: assert property (@(posedge mclk) disable iff (!rstn)
    (stk.pop && !stk.push) |=> (lvl_q[0] == $past(lvl_q[1])) && (lvl_q[1] == $past(lvl_q[2])))
    else $error("pop did not shift the stack up");
endmodule // trc_ret_stack

//--- logic/trc_core.sv
// Sequencer, register file and decode of the tiny RISC core
`timescale 1ns/100ps
module trc_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program memory, read data valid in the cycle its address is out
  output logic [8:0] pm_addr_q,
  input wire logic [15:0] pm_data,
  // I/O space
  output logic [5:0] io_addr_q,
  output logic [7:0] io_wdata_q,
  output logic io_we_q,
  output logic io_re_q,
  input wire logic [7:0] io_rdata,
  // Interrupts
  input wire logic [2:0] irq_req,
  output logic [2:0] irq_ack_q,
  output logic gie_q
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  trc_pkg::trc_state_e st_q, st_d;
  logic [15:0] ir_q, ir_d;
  logic [8:0] epc_q, epc_d, pc_d;
  logic vld_q, vld_d, gie_d, c_q, c_d, z_q, z_d;
  logic [2:0] ack_d;
  logic [5:0] io_addr_d;
  logic [7:0] io_wdata_d;
  logic io_we_d, io_re_d, in_int_q, in_int_d;
  logic [4:0] in_rd_q, in_rd_d;
  logic [7:0] rf_q [trc_pkg::TRC_NREG];
  logic rf_we;
  logic [4:0] rf_wa;
  logic [7:0] rf_wd;
  logic redirect, take_irq;
  logic [8:0] tgt, vec;
  logic [2:0] irq_lo;
  logic [3:0] opc;
  logic [4:0] rd5, rr5, rd_hi, ptr;
  logic [7:0] a_op, b_op, k_imm, sreg_rd;
  logic [8:0] diff;

  trc_stack_if stk ();

  trc_ret_stack u_stack (
    .mclk(mclk),
    .rstn(rstn),
    .stk(stk)
  );

  // ----------------------------------------------------------------
  // Field decode and operands
  // ----------------------------------------------------------------
  // one word per instruction
  assign opc = ir_q[15:12];
  assign rd5 = ir_q[9:5];
  assign rr5 = ir_q[4:0];
  // immediate forms reach only the upper half
  assign rd_hi = {1'b1, ir_q[7:4]};
  assign k_imm = {ir_q[11:8], ir_q[3:0]};
  assign ptr = rf_q[trc_pkg::TRC_PTR_REG][4:0];
  assign sreg_rd = {gie_q, 5'h00, z_q, c_q};
  // low 9 bits of the offset suffice, the space wraps at 512
  assign tgt = epc_q + ir_q[8:0] + trc_pkg::TRC_PC_INC;
  // Lowest pending source has the lowest vector
  assign irq_lo = irq_req & (~irq_req + 3'h1);
  assign vec = trc_pkg::TRC_VEC_BASE + {7'h00, irq_lo[2], irq_lo[1]};
  assign take_irq = (st_q == trc_pkg::TRC_ST_RUN) && vld_q && gie_q && (|irq_req);

  // ----------------------------------------------------------------
  // Execute: next-state logic
  // ----------------------------------------------------------------
  // Operand selection shared by the two-register and immediate ALU forms
  always_comb
  begin
    a_op = rf_q[rd5];
    b_op = rf_q[rr5];
    if (opc != trc_pkg::TRC_REG2_OP && opc != trc_pkg::TRC_MISC_OP)
    begin
      a_op = rf_q[rd_hi];
      b_op = k_imm;
    end
  end

  // Whole sequencer step; an interrupt replaces the word in execute
  always_comb
  begin
    diff = {1'b0, a_op} - {1'b0, b_op};
    pc_d = pm_addr_q + trc_pkg::TRC_PC_INC;
    ir_d = pm_data;
    epc_d = pm_addr_q;
    vld_d = 1'b1;
    st_d = trc_pkg::TRC_ST_RUN;
    gie_d = gie_q;
    c_d = c_q;
    z_d = z_q;
    ack_d = 3'h0;
    io_addr_d = io_addr_q;
    io_wdata_d = io_wdata_q;
    io_we_d = 1'b0;
    io_re_d = 1'b0;
    in_rd_d = in_rd_q;
    in_int_d = in_int_q;
    rf_we = 1'b0;
    rf_wa = rd_hi;
    rf_wd = diff[7:0];
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.push_addr = epc_q + trc_pkg::TRC_PC_INC;
    redirect = 1'b0;
    unique case (st_q)
      trc_pkg::TRC_ST_IN:
      begin
        // Second cycle of an I/O read: peripheral answers now
        rf_we = 1'b1;
        rf_wa = in_rd_q;
        rf_wd = in_int_q ? sreg_rd : io_rdata;
      end
      trc_pkg::TRC_ST_RUN:
      begin
        if (take_irq)
        begin
          gie_d = 1'b0;
          ack_d = irq_lo;
          // interrupted word is the return point
          stk.push = 1'b1;
          stk.push_addr = epc_q;
          pc_d = vec;
          redirect = 1'b1;
        end
        else if (vld_q)
        begin
          unique case (opc)
            trc_pkg::TRC_MISC_OP:
            begin
              rf_wa = ir_q[4:0];
              if (ir_q[11:8] == trc_pkg::TRC_SUBROUTINE_RETURN_SUB
                  || ir_q[11:8] == trc_pkg::TRC_INTERRUPT_RETURN_SUB)
              begin
                stk.pop = 1'b1;
                pc_d = stk.top;
                redirect = 1'b1;
                if (ir_q[11:8] == trc_pkg::TRC_INTERRUPT_RETURN_SUB)
                  gie_d = 1'b1;
              end
              else if (ir_q[11:8] == trc_pkg::TRC_INC_SUB)
              begin
                rf_we = 1'b1;
                rf_wd = rf_q[ir_q[4:0]] + 8'h01;
                z_d = (rf_wd == 8'h00);
              end
              else if (ir_q[11:8] == trc_pkg::TRC_LD_IND_SUB)
              begin
                rf_we = 1'b1;
                rf_wd = rf_q[ptr];
              end
              else if (ir_q[11:8] == trc_pkg::TRC_ST_IND_SUB)
              begin
                rf_we = 1'b1;
                rf_wa = ptr;
                rf_wd = rf_q[ir_q[4:0]];
              end
            end
            trc_pkg::TRC_REG2_OP:
            begin
              // two operands in, destination written, one cycle
              rf_we = 1'b1;
              rf_wa = rd5;
              unique case (ir_q[11:10])
                trc_pkg::TRC_ADD_SUB: {c_d, rf_wd} = {1'b0, a_op} + {1'b0, b_op};
                trc_pkg::TRC_SUBTRACT_SUB: {c_d, rf_wd} = diff;
                trc_pkg::TRC_AND_SUB: rf_wd = a_op & b_op;
                trc_pkg::TRC_MOV_SUB: rf_wd = b_op;
              endcase
              z_d = (rf_wd == 8'h00);
            end
            trc_pkg::TRC_SUB_IMM_WITH_CARRY_OP, trc_pkg::TRC_SUB_IMM_OP, trc_pkg::TRC_COMPARE_IMM_OP:
            begin
              if (opc == trc_pkg::TRC_SUB_IMM_WITH_CARRY_OP)
                diff = diff - {8'h00, c_q};
              // Compare only sets flags
              rf_we = (opc != trc_pkg::TRC_COMPARE_IMM_OP);
              rf_wd = diff[7:0];
              c_d = diff[8];
              z_d = (diff[7:0] == 8'h00);
            end
            trc_pkg::TRC_AND_IMM_OP, trc_pkg::TRC_OR_IMM_OP, trc_pkg::TRC_LOAD_CONSTANT_OP:
            begin
              rf_we = 1'b1;
              if (opc == trc_pkg::TRC_LOAD_CONSTANT_OP)
                rf_wd = k_imm;
              else
              begin
                rf_wd = (opc == trc_pkg::TRC_AND_IMM_OP) ? (a_op & k_imm) : (a_op | k_imm);
                z_d = (rf_wd == 8'h00);
              end
            end
            trc_pkg::TRC_IO_OP:
            begin
              io_addr_d = ir_q[10:5];
              if (ir_q[11])
              begin
                io_wdata_d = rf_q[ir_q[4:0]];
                // Status register lives here and is not forwarded
                if (ir_q[10:5] == trc_pkg::TRC_IO_STATUS)
                begin
                  gie_d = io_wdata_d[trc_pkg::TRC_SR_I];
                  z_d = io_wdata_d[trc_pkg::TRC_SR_Z];
                  c_d = io_wdata_d[trc_pkg::TRC_SR_C];
                end
                else
                  io_we_d = 1'b1;
              end
              else
              begin
                // Read stalls one cycle; outputs are registered
                in_rd_d = ir_q[4:0];
                in_int_d = (ir_q[10:5] == trc_pkg::TRC_IO_STATUS);
                io_re_d = !in_int_d;
                st_d = trc_pkg::TRC_ST_IN;
                pc_d = pm_addr_q;
                ir_d = ir_q;
                epc_d = epc_q;
              end
            end
            trc_pkg::TRC_RELATIVE_JUMP_OP, trc_pkg::TRC_RELATIVE_CALL_OP:
            begin
              pc_d = tgt;
              redirect = 1'b1;
              stk.push = (opc == trc_pkg::TRC_RELATIVE_CALL_OP);
            end
            default:
            begin
              // Unused opcodes behave as no operation
            end
          endcase
        end
      end
    endcase
    // flush the prefetched word on any flow change
    if (redirect)
      vld_d = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // fetch restarts at word zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= trc_pkg::TRC_ST_RUN;
      pm_addr_q <= trc_pkg::TRC_PC_RST;
      ir_q <= 16'h0000;
      epc_q <= trc_pkg::TRC_PC_RST;
      vld_q <= 1'b0;
      gie_q <= 1'b0;
      c_q <= 1'b0;
      z_q <= 1'b0;
      irq_ack_q <= 3'h0;
      io_addr_q <= 6'h00;
      io_wdata_q <= 8'h00;
      io_we_q <= 1'b0;
      io_re_q <= 1'b0;
      in_rd_q <= 5'h00;
      in_int_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pm_addr_q <= pc_d;
      ir_q <= ir_d;
      epc_q <= epc_d;
      vld_q <= vld_d;
      gie_q <= gie_d;
      c_q <= c_d;
      z_q <= z_d;
      irq_ack_q <= ack_d;
      io_addr_q <= io_addr_d;
      io_wdata_q <= io_wdata_d;
      io_we_q <= io_we_d;
      io_re_q <= io_re_d;
      in_rd_q <= in_rd_d;
      in_int_q <= in_int_d;
    end
  end

  // register file, data only, no reset
  always_ff @(posedge mclk)
  begin
    if (rf_we)
      rf_q[rf_wa] <= rf_wd;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // reset fetch
  chk_reset_fetch_zero: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rstn) |-> (pm_addr_q == 9'h000) && !vld_q)
    else $error("fetch did not start at word zero");
  chk_fetch_step_one: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == trc_pkg::TRC_ST_RUN && !redirect && st_d == trc_pkg::TRC_ST_RUN)
      |=> (pm_addr_q == $past(pm_addr_q) + 9'h001) && vld_q)
    else $error("prefetch did not advance by one");
  chk_jump_target_flush: assert property (@(posedge mclk) disable iff (!rstn)
    (!take_irq && vld_q && st_q == trc_pkg::TRC_ST_RUN && opc == trc_pkg::TRC_RELATIVE_JUMP_OP)
      |=> (pm_addr_q == $past(epc_q) + $past(ir_q[8:0]) + 9'h001) && !vld_q ##1 vld_q)
    else $error("relative jump target or flush wrong");
  chk_call_push_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (!take_irq && vld_q && st_q == trc_pkg::TRC_ST_RUN && opc == trc_pkg::TRC_RELATIVE_CALL_OP)
      |-> stk.push && (stk.push_addr == epc_q + 9'h001))
    else $error("call pushed wrong return address");
  chk_return_pc_load: assert property (@(posedge mclk) disable iff (!rstn)
    stk.pop |=> (pm_addr_q == $past(stk.top)) && !vld_q)
    else $error("return did not load the stack top");
  chk_irq_take_prio: assert property (@(posedge mclk) disable iff (!rstn)
    take_irq |=> !gie_q && (irq_ack_q == ($past(irq_req) & (~$past(irq_req) + 3'h1)))
      && (pm_addr_q == 9'h001 + {7'h00, irq_ack_q[2], irq_ack_q[1]}))
    else $error("interrupt priority or enable clear wrong");
  chk_irq_gated_off: assert property (@(posedge mclk) disable iff (!rstn)
    !gie_q |=> irq_ack_q == 3'h0)
    else $error("interrupt taken with global enable clear");
  // immediate forms write upper half only
  chk_imm_upper_half: assert property (@(posedge mclk) disable iff (!rstn)
    (rf_we && st_q == trc_pkg::TRC_ST_RUN && opc >= trc_pkg::TRC_SUB_IMM_WITH_CARRY_OP
      && opc <= trc_pkg::TRC_LOAD_CONSTANT_OP) |-> rf_wa[4])
    else $error("immediate form wrote a lower register");
  chk_add_writeback: assert property (@(posedge mclk) disable iff (!rstn)
    (!take_irq && vld_q && st_q == trc_pkg::TRC_ST_RUN && opc == trc_pkg::TRC_REG2_OP
      && ir_q[11:10] == trc_pkg::TRC_ADD_SUB)
      |=> rf_q[$past(rd5)] == $past(rf_q[rd5] + rf_q[rr5]))
    else $error("two-register add result wrong");
  chk_io_write_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (!take_irq && vld_q && st_q == trc_pkg::TRC_ST_RUN && opc == trc_pkg::TRC_IO_OP && ir_q[11]
      && ir_q[10:5] != trc_pkg::TRC_IO_STATUS) |=> io_we_q && (io_addr_q == $past(ir_q[10:5]))
      && (io_wdata_q == $past(rf_q[ir_q[4:0]])))
    else $error("I/O write not issued correctly");
  // strobe only for an executed write
  chk_io_strobe_cause: assert property (@(posedge mclk) disable iff (!rstn)
    io_we_q |-> $past(!take_irq && vld_q && st_q == trc_pkg::TRC_ST_RUN && opc == trc_pkg::TRC_IO_OP && ir_q[11]))
    else $error("I/O write strobe without a write instruction");
endmodule // trc_core

//--- testbench/trc_mem_model.sv
// Behavioural program flash and I/O space facing the core
`timescale 1ns/100ps
module trc_mem_model (
  // Clock
  mclk,
  // Program memory
  pm_addr_q,
  pm_data,
  // I/O space
  io_addr_q,
  io_wdata_q,
  io_we_q,
  io_re_q,
  io_rdata
);
  input wire logic mclk;
  input wire logic [8:0] pm_addr_q;
  output logic [15:0] pm_data;
  input wire logic [5:0] io_addr_q;
  input wire logic [7:0] io_wdata_q;
  input wire logic io_we_q;
  input wire logic io_re_q;
  output logic [7:0] io_rdata;
  logic [15:0] flash [0:511];
  logic [7:0] io_mem [0:63];
  // Flash read is combinational: the word is there in the cycle its address is out
  assign pm_data = flash[pm_addr_q];
  // Outside a read strobe the data is inverted, so a stale byte never looks valid
  assign io_rdata = io_re_q ? io_mem[io_addr_q] : ~io_mem[io_addr_q];
  // Peripheral write port; plain always since the bench preloads the array too
  always @(posedge mclk)
  begin
    if (io_we_q === 1'b1)
      io_mem[io_addr_q] <= io_wdata_q;
  end
endmodule // trc_mem_model

//--- testbench/trc_core_tb.sv
// Self-checking bench for the tiny RISC core sequencer
`timescale 1ns/100ps
module trc_core_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] irq_req = 3'h0;
  logic [8:0] pm_addr_q;
  logic [15:0] pm_data;
  logic [5:0] io_addr_q;
  logic [7:0] io_wdata_q;
  logic [7:0] io_rdata;
  logic io_we_q;
  logic io_re_q;
  logic gie_q;
  logic gie_prev = 1'b0;
  logic [2:0] irq_ack_q;
  logic [13:0] wlog [$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // Clock of 4 ns
  always #2 mclk = ~mclk;
  trc_core dut (.mclk(mclk), .rstn(rstn), .pm_addr_q(pm_addr_q), .pm_data(pm_data), .io_addr_q(io_addr_q),
    .io_wdata_q(io_wdata_q), .io_we_q(io_we_q), .io_re_q(io_re_q), .io_rdata(io_rdata), .irq_req(irq_req),
    .irq_ack_q(irq_ack_q), .gie_q(gie_q));
  trc_mem_model mem (.mclk(mclk), .pm_addr_q(pm_addr_q), .pm_data(pm_data), .io_addr_q(io_addr_q),
    .io_wdata_q(io_wdata_q), .io_we_q(io_we_q), .io_re_q(io_re_q), .io_rdata(io_rdata));
  // Log of I/O writes, enable history and the hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    gie_prev <= gie_q;
    if (io_we_q === 1'b1)
      wlog.push_back({io_addr_q, io_wdata_q});
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Encoders, compare and sequencing helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] f_ldi(input logic [4:0] r, input logic [7:0] k);
    return {trc_pkg::TRC_LOAD_CONSTANT_OP, k[7:4], r[3:0], k[3:0]};
  endfunction
  function automatic logic [15:0] f_imm(input logic [3:0] op, input logic [4:0] r, input logic [7:0] k);
    return {op, k[7:4], r[3:0], k[3:0]};
  endfunction
  function automatic logic [15:0] f_io(input logic w, input logic [5:0] a, input logic [4:0] r);
    return {trc_pkg::TRC_IO_OP, w, a, r};
  endfunction
  function automatic logic [15:0] f_rr(input logic [1:0] s, input logic [4:0] d, input logic [4:0] r);
    return {trc_pkg::TRC_REG2_OP, s, d, r};
  endfunction
  function automatic logic [15:0] f_rel(input logic [3:0] op, input logic [11:0] k);
    return {op, k};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_w(input int idx, input logic [13:0] exp);
    chk("io write", {2'h0, exp}, (wlog.size() > idx) ? {2'h0, wlog[idx]} : 16'hffff);
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // Hold reset six cycles and blank the flash; program is loaded meanwhile
  task automatic hold;
    @(posedge mclk);
    rstn <= 1'b0;
    irq_req <= 3'h0;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 512; i++)
      mem.flash[i] = 16'h0000;
    wlog.delete();
  endtask
  task automatic go;
    chk("reset pc", 16'h0000, {7'h00, pm_addr_q});
    @(posedge mclk);
    rstn <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_alu;
    hold();
    mem.flash[0] = f_ldi(5'd16, 8'h0f);
    mem.flash[1] = f_ldi(5'd31, 8'h03);
    mem.flash[2] = f_rr(trc_pkg::TRC_MOV_SUB, 5'd0, 5'd16);
    mem.flash[3] = f_rr(trc_pkg::TRC_ADD_SUB, 5'd0, 5'd31);
    mem.flash[4] = f_io(1'b1, 6'h05, 5'd0);
    mem.flash[5] = f_rr(trc_pkg::TRC_SUBTRACT_SUB, 5'd0, 5'd31);
    mem.flash[6] = f_io(1'b1, 6'h06, 5'd0);
    mem.flash[7] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'hfff);
    go();
    tick();
    chk("pc step", 16'h0001, {7'h00, pm_addr_q});
    tick();
    chk("pc step", 16'h0002, {7'h00, pm_addr_q});
    repeat (20) tick();
    chk_w(0, {6'h05, 8'h12});
    chk_w(1, {6'h06, 8'h0f});
    chk("write count", 16'h0002, 16'(wlog.size()));
  endtask
  task automatic t_ind;
    hold();
    mem.io_mem[6'h22] = 8'ha5;
    mem.flash[0] = f_ldi(5'd30, 8'h05);
    mem.flash[1] = f_ldi(5'd20, 8'h5a);
    mem.flash[2] = f_rr(trc_pkg::TRC_MOV_SUB, 5'd5, 5'd20);
    mem.flash[3] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_LD_IND_SUB, 8'h01};
    mem.flash[4] = f_io(1'b1, 6'h3e, 5'd1);
    mem.flash[5] = f_io(1'b0, 6'h22, 5'd2);
    mem.flash[6] = f_io(1'b1, 6'h23, 5'd2);
    mem.flash[7] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'h0f8);
    mem.flash[8] = f_io(1'b1, 6'h00, 5'd2);
    mem.flash[256] = f_io(1'b1, 6'h24, 5'd2);
    mem.flash[257] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'h7ff);
    go();
    repeat (30) tick();
    chk_w(0, {6'h3e, 8'h5a});
    chk_w(1, {6'h23, 8'ha5});
    chk_w(2, {6'h24, 8'ha5});
    chk("write count", 16'h0003, 16'(wlog.size()));
  endtask
  // Immediate forms and flags, status read, single-register and indirect store
  task automatic t_imm;
    hold();
    mem.flash[0] = f_ldi(5'd17, 8'h20);
    mem.flash[1] = f_imm(trc_pkg::TRC_SUB_IMM_OP, 5'd17, 8'h01);
    mem.flash[2] = f_imm(trc_pkg::TRC_SUB_IMM_WITH_CARRY_OP, 5'd17, 8'h20);
    mem.flash[3] = f_imm(trc_pkg::TRC_SUB_IMM_WITH_CARRY_OP, 5'd17, 8'h00);
    mem.flash[4] = f_imm(trc_pkg::TRC_COMPARE_IMM_OP, 5'd17, 8'hfe);
    mem.flash[5] = f_io(1'b0, trc_pkg::TRC_IO_STATUS, 5'd3);
    mem.flash[6] = f_io(1'b1, 6'h10, 5'd3);
    mem.flash[7] = f_io(1'b1, 6'h11, 5'd17);
    mem.flash[8] = f_imm(trc_pkg::TRC_AND_IMM_OP, 5'd17, 8'h3c);
    mem.flash[9] = f_imm(trc_pkg::TRC_OR_IMM_OP, 5'd17, 8'h41);
    mem.flash[10] = f_rr(trc_pkg::TRC_MOV_SUB, 5'd4, 5'd17);
    mem.flash[11] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_INC_SUB, 8'h04};
    mem.flash[12] = f_rr(trc_pkg::TRC_AND_SUB, 5'd4, 5'd17);
    mem.flash[13] = f_ldi(5'd30, 8'h09);
    mem.flash[14] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_ST_IND_SUB, 8'h04};
    mem.flash[15] = f_io(1'b1, 6'h12, 5'd9);
    mem.flash[16] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'hfff);
    go();
    repeat (30) tick();
    chk_w(0, {6'h10, 8'h02});
    chk_w(1, {6'h11, 8'hfe});
    chk_w(2, {6'h12, 8'h7c});
    chk("write count", 16'h0003, 16'(wlog.size()));
  endtask
  // Four nested calls: the oldest return address must be lost
  task automatic t_stack;
    hold();
    mem.flash[0] = f_ldi(5'd16, 8'hc3);
    mem.flash[1] = f_rel(trc_pkg::TRC_RELATIVE_CALL_OP, 12'h01e);
    mem.flash[2] = f_io(1'b1, 6'h00, 5'd16);
    mem.flash[3] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'hfff);
    for (int i = 0; i < 3; i++)
    begin
      mem.flash[32 + 16 * i] = f_rel(trc_pkg::TRC_RELATIVE_CALL_OP, 12'h00f);
      mem.flash[33 + 16 * i] = f_io(1'b1, 6'(i + 1), 5'd16);
      mem.flash[34 + 16 * i] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_SUBROUTINE_RETURN_SUB, 8'h00};
    end
    mem.flash[80] = f_io(1'b1, 6'h04, 5'd16);
    mem.flash[81] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_SUBROUTINE_RETURN_SUB, 8'h00};
    go();
    repeat (60) tick();
    chk_w(0, {6'h04, 8'hc3});
    chk_w(1, {6'h03, 8'hc3});
    chk_w(2, {6'h02, 8'hc3});
    chk_w(3, {6'h01, 8'hc3});
    chk_w(4, {6'h01, 8'hc3});
  endtask
  // All three requests raised at once, served lowest vector first
  task automatic t_irq;
    int n;
    hold();
    mem.flash[0] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'h00f);
    for (int v = 1; v < 4; v++)
    begin
      mem.flash[v] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'(63 + 3 * v));
      mem.flash[64 + 4 * v] = f_io(1'b1, 6'(8 + v), 5'd16);
      mem.flash[65 + 4 * v] = {trc_pkg::TRC_MISC_OP, trc_pkg::TRC_INTERRUPT_RETURN_SUB, 8'h00};
    end
    mem.flash[16] = f_ldi(5'd16, 8'h80);
    mem.flash[17] = f_io(1'b1, trc_pkg::TRC_IO_STATUS, 5'd16);
    mem.flash[18] = f_rel(trc_pkg::TRC_RELATIVE_JUMP_OP, 12'hfff);
    irq_req <= 3'h7;
    go();
    for (int v = 1; v < 4; v++)
    begin
      n = 0;
      while (irq_ack_q !== 3'h0 && n < 200)
      begin
        tick();
        n++;
      end
      n = 0;
      while (irq_ack_q === 3'h0 && n < 200)
      begin
        tick();
        n++;
      end
      chk("ack", {13'h0000, 3'(1 << (v - 1))}, {13'h0000, irq_ack_q});
      chk("vector", 16'(v), {7'h00, pm_addr_q});
      chk("enable", 16'h0010, {11'h000, gie_prev, 3'h0, gie_q});
      @(posedge mclk);
      irq_req[v - 1] <= 1'b0;
    end
    repeat (20) tick();
    chk_w(0, {6'h09, 8'h80});
    chk_w(1, {6'h0a, 8'h80});
    chk_w(2, {6'h0b, 8'h80});
    chk("enable back", 16'h0001, {15'h0000, gie_q});
  endtask
  task automatic test_done;
    $display("TB: checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    t_alu();
    t_ind();
    t_imm();
    t_stack();
    t_irq();
    test_done();
  end
endmodule // trc_core_tb
